// >>> rmcc_pkg.sv
// Summary of operation
// - In bypass, system divider code n divides the source by n+1.
// - With PLL in use, a too-low divider reads back as the minimum divider.
// - Bit 22 enables the system divider; PLL operation always applies it.
// - Bit 20 set clocks PWM from the predivider instead of the system clock.
// - PWM field 19:17 (reset 7) gives /2../32, codes 5..7 all /64.
// - PWM clock divides by powers of two, edges aligned to system clock.
// - Bit 13 drives PLL power-down directly; reset 1 keeps PLL off.
// - Bit 12 (reset 1) set blocks PLL clock output; cleared passes it.
// - Bit 11 (reset 1) set selects oscillator; cleared selects divided PLL.
// - Bit 10 enables PLL check timer; a PLL stop raises an interrupt.
// - Oscillator select: 00 main, 01 internal, 10 internal/4, 11 reserved.
package rmcc_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] RMCC_RCC_ADDR = 8'h60;
   localparam logic [7:0] RMCC_STAT_ADDR = 8'h64;
   localparam logic [31:0] RMCC_RCC_RESET = 32'h078e3ac0;
   localparam logic [31:0] RMCC_RCC_WMASK = 32'h07de3ff0;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int RMCC_SYSTEM_CLOCK_DIVISOR_LSB = 23;
   localparam int RMCC_USESYS_BIT = 22;
   localparam int RMCC_USEPWM_BIT = 20;
   localparam int RMCC_PWMSEL_LSB = 17;
   localparam int RMCC_PWROFF_BIT = 13;
   localparam int RMCC_GATE_BIT = 12;
   localparam int RMCC_BYPASS_BIT = 11;
   localparam int RMCC_CHECK_BIT = 10;
   localparam int RMCC_OSCSEL_LSB = 4;
   // ----------------------------------------
   // Values
   // ----------------------------------------
   localparam logic [3:0] RMCC_MIN_DIV = 4'h7;
   localparam logic [2:0] RMCC_PWM_MAXCODE = 3'h5;
   localparam logic [1:0] RMCC_OSC_MAIN = 2'h0;
   localparam logic [1:0] RMCC_OSC_INT = 2'h1;
   localparam logic [1:0] RMCC_OSC_INT4 = 2'h2;
   localparam logic [1:0] RMCC_OSC_RSVD = 2'h3;
   localparam int RMCC_CHECK_WINDOW = 64;
   localparam logic [1:0] RMCC_RESP_OKAY = 2'h0;
   localparam logic [1:0] RMCC_RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {RMCC_SRC_OSC, RMCC_SRC_SWITCH, RMCC_SRC_PLL} rmcc_src_t;
endpackage

// >>> rmcc_div_if.sv
`timescale 1ns/1ps
interface rmcc_div_if;
   logic [3:0] divCode;
   logic divEnable;
   logic divTick;
   logic divSync;
   modport owner (output divCode, output divEnable, input divTick, output divSync);
   modport divider (input divCode, input divEnable, output divTick, input divSync);
endinterface

// >>> rmcc_divider.sv
`timescale 1ns/1ps
module rmcc_divider
   import rmcc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Control
   rmcc_div_if.divider dv
);
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic wrap;
   // ----------------------------------------
   // Divide by code plus one
   // ----------------------------------------
   assign wrap = (cnt_r >= dv.divCode);
   assign cnt_nxt = (wrap || dv.divSync) ? 4'h0 : cnt_r + 4'h1;
   assign dv.divTick = dv.divEnable && wrap;
   always_ff @(posedge sys_clk) begin
      if (rst) cnt_r <= 4'h0;
      else if (dv.divEnable) cnt_r <= cnt_nxt;
      else cnt_r <= 4'h0;
   end
endmodule // rmcc_divider

// >>> rmcc_top.sv
`timescale 1ns/1ps
module rmcc_top
   import rmcc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // PLL
   input wire logic pllAlive,
   output logic pllPowerOff,
   output logic pllOutputGate,
   // Clock enables, source select and status
   output logic sysClkEn,
   output logic pwmClkEn,
   output logic [1:0] oscSelect,
   output logic sysFromPll,
   output logic pllFail
);
   // ----------------------------------------
   // Configuration register
   // ----------------------------------------
   logic [31:0] rcc_r;
   logic [31:0] rcc_nxt;
   logic fail_r;
   logic [3:0] system_clock_divisor;
   logic [2:0] pwmSel;
   logic bypass;
   logic useSys;
   logic pllUsed;
   logic [3:0] sysDivRead;
   logic [31:0] rccRead;
   assign system_clock_divisor = rcc_r[RMCC_SYSTEM_CLOCK_DIVISOR_LSB +: 4];
   assign pwmSel = rcc_r[RMCC_PWMSEL_LSB +: 3];
   assign bypass = rcc_r[RMCC_BYPASS_BIT];
   assign useSys = rcc_r[RMCC_USESYS_BIT];
   assign pllUsed = !bypass;
   assign sysDivRead = (pllUsed && system_clock_divisor < RMCC_MIN_DIV) ? RMCC_MIN_DIV : system_clock_divisor;
   always_comb begin
      rccRead = rcc_r & RMCC_RCC_WMASK;
      rccRead[RMCC_SYSTEM_CLOCK_DIVISOR_LSB +: 4] = sysDivRead;
   end
   assign pllPowerOff = rcc_r[RMCC_PWROFF_BIT];
   assign pllOutputGate = rcc_r[RMCC_GATE_BIT];
   assign oscSelect = rcc_r[RMCC_OSCSEL_LSB +: 2];
   // ----------------------------------------
   // AXI4-Lite write
   // ----------------------------------------
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic doWrite;
   logic wrHit;
   logic wrStat;
   assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
   assign s_axi_wready = s_axi_awready;
   assign doWrite = s_axi_awready;
   assign wrHit = s_axi_awaddr == RMCC_RCC_ADDR;
   assign wrStat = s_axi_awaddr == RMCC_STAT_ADDR;
   always_comb begin
      rcc_nxt = rcc_r;
      for (int b = 0; b < 4; b++) begin
         if (s_axi_wstrb[b]) rcc_nxt[b*8 +: 8] = s_axi_wdata[b*8 +: 8];
      end
      rcc_nxt = (rcc_nxt & RMCC_RCC_WMASK) | (RMCC_RCC_RESET & ~RMCC_RCC_WMASK);
   end
   always_ff @(posedge sys_clk) begin
      if (rst) rcc_r <= RMCC_RCC_RESET;
      else if (doWrite && wrHit) rcc_r <= rcc_nxt;
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bvalid_r <= 1'b0;
         bresp_r <= RMCC_RESP_OKAY;
      end else if (doWrite) begin
         bvalid_r <= 1'b1;
         bresp_r <= (wrHit || wrStat) ? RMCC_RESP_OKAY : RMCC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   // ----------------------------------------
   // AXI4-Lite read
   // ----------------------------------------
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic [31:0] statWord;
   assign s_axi_arready = !rvalid_r;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= RMCC_RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_r) begin
         rvalid_r <= 1'b1;
         rdata_r <= (s_axi_araddr == RMCC_RCC_ADDR) ? rccRead :
                    (s_axi_araddr == RMCC_STAT_ADDR) ? statWord : 32'h0;
         rresp_r <= (s_axi_araddr == RMCC_RCC_ADDR || s_axi_araddr == RMCC_STAT_ADDR) ?
                    RMCC_RESP_OKAY : RMCC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   // ----------------------------------------
   // PLL alive synchroniser and check timer
   // ----------------------------------------
   logic alive1_r;
   logic pllAlive_s;
   logic alivePrev_r;
   logic [6:0] watch_r;
   logic aliveEdge;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         alive1_r <= 1'b0;
         pllAlive_s <= 1'b0;
         alivePrev_r <= 1'b0;
      end else begin
         alive1_r <= pllAlive;
         pllAlive_s <= alive1_r;
         alivePrev_r <= pllAlive_s;
      end
   end
   assign aliveEdge = pllAlive_s != alivePrev_r;
   assign statWord = {28'h0, fail_r, sysFromPll, pllAlive_s, 1'b0};
   always_ff @(posedge sys_clk) begin
      if (rst || !rcc_r[RMCC_CHECK_BIT] || aliveEdge) watch_r <= 7'h0;
      else if (watch_r != 7'(RMCC_CHECK_WINDOW)) watch_r <= watch_r + 7'h1;
   end
   always_ff @(posedge sys_clk) begin
      if (rst) fail_r <= 1'b0;
      else if (rcc_r[RMCC_CHECK_BIT] && watch_r == 7'(RMCC_CHECK_WINDOW)) fail_r <= 1'b1;
      else if (doWrite && wrStat && s_axi_wstrb[0] && s_axi_wdata[3]) fail_r <= 1'b0;
   end
   assign pllFail = fail_r;
   // ----------------------------------------
   // Glitch-free source switch
   // ----------------------------------------
   rmcc_src_t src_r;
   rmcc_src_t src_nxt;
   logic wantPll;
   logic divBoundary;
   rmcc_div_if sdv ();
   assign wantPll = pllUsed;
   always_comb begin
      case (src_r)
         RMCC_SRC_OSC: src_nxt = wantPll ? RMCC_SRC_SWITCH : RMCC_SRC_OSC;
         RMCC_SRC_SWITCH: src_nxt = divBoundary ? (wantPll ? RMCC_SRC_PLL : RMCC_SRC_OSC) : RMCC_SRC_SWITCH;
         RMCC_SRC_PLL: src_nxt = wantPll ? RMCC_SRC_PLL : RMCC_SRC_SWITCH;
         default: src_nxt = RMCC_SRC_OSC;
      endcase
   end
   always_ff @(posedge sys_clk) begin
      if (rst) src_r <= RMCC_SRC_OSC;
      else src_r <= src_nxt;
   end
   assign sysFromPll = src_r == RMCC_SRC_PLL;
   // ----------------------------------------
   // System divider
   // ----------------------------------------
   logic divOn;
   assign divOn = useSys || src_r != RMCC_SRC_OSC;
   assign sdv.divCode = (src_r != RMCC_SRC_OSC) ? sysDivRead : system_clock_divisor;
   assign sdv.divEnable = divOn;
   assign sdv.divSync = 1'b0;
   assign divBoundary = !divOn || sdv.divTick;
   rmcc_divider u_system_clock_divisor (
      .sys_clk(sys_clk),
      .rst(rst),
      .dv(sdv.divider)
   );
   assign sysClkEn = src_r == RMCC_SRC_SWITCH ? 1'b0 : (divOn ? sdv.divTick : 1'b1);
   // ----------------------------------------
   // PWM predivider
   // ----------------------------------------
   logic [5:0] pwmCnt_r;
   logic [5:0] pwmMask;
   logic [2:0] pwmCode;
   assign pwmCode = (pwmSel > RMCC_PWM_MAXCODE) ? RMCC_PWM_MAXCODE : pwmSel;
   assign pwmMask = 6'((7'h2 << pwmCode) - 7'h1);
   always_ff @(posedge sys_clk) begin
      if (rst) pwmCnt_r <= 6'h0;
      else if (sysClkEn) pwmCnt_r <= pwmCnt_r + 6'h1;
   end
   assign pwmClkEn = rcc_r[RMCC_USEPWM_BIT] ? (sysClkEn && (pwmCnt_r & pwmMask) == pwmMask) : sysClkEn;
endmodule // rmcc_top

// >>> rmcc_checker_assertions.sv
`timescale 1ns/1ps
module rmcc_checker
   import rmcc_pkg::*;
(
   // Watched ports
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [1:0] s_axi_rresp,
   input wire logic [31:0] s_axi_rdata,
   input wire logic pllPowerOff,
   input wire logic pllOutputGate,
   input wire logic [1:0] oscSelect,
   input wire logic sysClkEn,
   input wire logic pwmClkEn,
   input wire logic sysFromPll
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire wTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire cfgTake = wTake && s_axi_awaddr == RMCC_RCC_ADDR;
   wire badRd = s_axi_arvalid && s_axi_arready && s_axi_araddr != RMCC_RCC_ADDR && s_axi_araddr != RMCC_STAT_ADDR;
   a_write_answer: assert property (wTake |=> s_axi_bvalid) else $error("write not answered");
   a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
   a_unmapped_read: assert property (badRd |=> s_axi_rvalid && s_axi_rresp == RMCC_RESP_SLVERR && s_axi_rdata == 0)
      else $error("unmapped read answer wrong");
   a_power_bit: assert property (cfgTake && s_axi_wstrb[1] |=> pllPowerOff == $past(s_axi_wdata[13]))
      else $error("power-off not from bit 13");
   a_gate_bit: assert property (cfgTake && s_axi_wstrb[1] |=> pllOutputGate == $past(s_axi_wdata[12]))
      else $error("gate not from bit 12");
   a_osc_field: assert property (cfgTake && s_axi_wstrb[0] |=> oscSelect == $past(s_axi_wdata[5:4]))
      else $error("osc select not from 5:4");
   a_pwm_aligned: assert property (pwmClkEn |-> sysClkEn) else $error("pwm tick off system tick");
   a_reset_state: assert property ($fell(rst) |-> pllPowerOff && pllOutputGate && oscSelect == 0 && !sysFromPll)
      else $error("reset state wrong");
endmodule // rmcc_checker
bind rmcc_top rmcc_checker chk_u (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
   .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rresp, .s_axi_rdata, .pllPowerOff, .pllOutputGate, .oscSelect,
   .sysClkEn, .pwmClkEn, .sysFromPll);

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import rmcc_pkg::*;
   logic sys_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pllAlive, pllPowerOff, pllOutputGate;
   logic sysClkEn, pwmClkEn, sysFromPll, pllFail, aliveRun;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, w, rdat;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, oscSelect, rsp;
   int n_fail = 0, tests_run = 0, seed = 73861, k;
   rmcc_top dut_u (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pllAlive, .pllPowerOff,
      .pllOutputGate, .sysClkEn, .pwmClkEn, .oscSelect, .sysFromPll, .pllFail);
   initial begin
      sys_clk = 0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) pllAlive <= aliveRun ? ~pllAlive : pllAlive;
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function logic [31:0] cfg(input logic [3:0] sd, input logic us, up, input logic [2:0] pc, input logic by, pw);
      return {5'h0, sd, us, 1'b0, up, pc, 3'h0, pw, pw, by, 11'h0};
   endfunction
   function logic [31:0] expv(input logic [31:0] d);
      logic [31:0] v;
      v = d & RMCC_RCC_WMASK;
      if (!v[11] && v[26:23] < RMCC_MIN_DIV) v[26:23] = RMCC_MIN_DIV;
      return v;
   endfunction
   task chk(input logic [31:0] g, e);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do @(posedge sys_clk); while (!(s_axi_awready && s_axi_wready));
      s_axi_awvalid <= 0;
      s_axi_wvalid <= 0;
      while (!s_axi_bvalid) @(posedge sys_clk);
      rsp = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task axr(input logic [7:0] a);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(posedge sys_clk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      while (!s_axi_rvalid) @(posedge sys_clk);
      rdat = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   task per(input logic pw, input int ex);
      int c;
      repeat (2) begin
         @(negedge sys_clk);
         for (c = 0; c < 300 && !(pw ? pwmClkEn : sysClkEn); c++) @(negedge sys_clk);
      end
      @(negedge sys_clk);
      for (c = 1; c < 300 && !(pw ? pwmClkEn : sysClkEn); c++) @(negedge sys_clk);
      chk(c, ex);
   endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      {rst, aliveRun, pllAlive, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 8'h80;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hf};
      repeat (4) @(posedge sys_clk);
      rst <= 0;
      aliveRun <= 1;
      axr(RMCC_RCC_ADDR);
      chk(rdat, RMCC_RCC_RESET);
      chk({pllPowerOff, pllOutputGate, sysFromPll, oscSelect}, 5'h18);
      $display("reset test done");
      repeat (12) begin
         w = $random(seed) & 32'hfbde3fff;
         axw(RMCC_RCC_ADDR, w);
         axr(RMCC_RCC_ADDR);
         chk(rdat, expv(w));
         chk({pllPowerOff, pllOutputGate, oscSelect}, {w[13:12], w[5:4]});
      end
      $display("random test done");
      for (int n = 1; n < 16; n += 7) begin
         axw(RMCC_RCC_ADDR, cfg(4'(n), 1, 0, 0, 1, 1));
         per(0, n + 1);
      end
      axw(RMCC_RCC_ADDR, cfg(4'h9, 0, 0, 0, 1, 1));
      per(0, 1);
      for (int c = 0; c < 8; c++) begin
         axw(RMCC_RCC_ADDR, cfg(4'hf, 0, 1, 3'(c), 1, 1));
         per(1, c < 5 ? 2 << c : 64);
      end
      axw(RMCC_RCC_ADDR, cfg(4'hf, 0, 0, 3'h2, 1, 1));
      per(1, 1);
      $display("divider test done");
      axw(RMCC_RCC_ADDR, cfg(4'h9, 0, 0, 0, 0, 0) | 32'h400);
      per(0, 10);
      chk(sysFromPll, 1);
      axw(RMCC_STAT_ADDR, 32'h8);
      chk(pllFail, 0);
      aliveRun <= 0;
      for (k = 0; k < 300 && !pllFail; k++) @(posedge sys_clk);
      chk(pllFail, 1);
      aliveRun <= 1;
      repeat (6) @(posedge sys_clk);
      axw(RMCC_STAT_ADDR, 32'h8);
      chk(pllFail, 0);
      $display("pll test done");
      axr(8'h70);
      chk(rsp, RMCC_RESP_SLVERR);
      chk(rdat, 32'h0);
      axw(8'h70, 32'h1);
      chk(rsp, RMCC_RESP_SLVERR);
      axw(RMCC_RCC_ADDR, RMCC_RCC_RESET);
      per(0, 1);
      chk(sysFromPll, 0);
      $display("bus test done");
      final_report;
   end
   initial begin
      #200000;
      n_fail++;
      final_report;
   end
endmodule // tb_top
